// ---- hdl/miu_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module miu_top import miu_pkg::*; #(
  parameter int NUM_REQ   = 8,
  parameter int IDX_W     = 3,
  parameter bit LOW_FIRST = 1'b1
) (
  // clock and reset
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst,
  // requesting elements
  input  wire logic [NUM_REQ-1:0]           i_el_req,
  input  wire miu_cw_t [NUM_REQ-1:0]        i_el_cw,
  input  wire logic [NUM_REQ-1:0][WORD_W-1:0] i_el_wdata,
  output logic [NUM_REQ-1:0]                o_el_done,
  output logic [NUM_REQ-1:0]                o_el_err,
  output logic [WORD_W-1:0]                 o_el_rdata,
  output logic                              o_busy,
  // memory modules
  output miu_mem_out_t                      o_mem,
  input  wire miu_mem_in_t                  i_mem,
  // interrupt section and error register
  input  wire logic                         i_intr_enable,
  output logic                              o_err_intr,
  input  wire logic                         i_per_rd,
  output logic [WORD_W-1:0]                 o_per_rdata,
  output logic                              o_per_full
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MCW,
    ST_DATA,
    ST_FETCH,
    ST_DONE
  } miu_state_t;

  miu_state_t        state;
  miu_state_t        next_state;
  miu_cw_t           cw;
  miu_cw_t           next_cw;
  logic [WORD_W-1:0] mbr;
  logic [WORD_W-1:0] next_mbr;
  logic              mbr_par;
  logic              next_mbr_par;
  logic [WORD_W-1:0] dbr;
  logic [WORD_W-1:0] next_dbr;
  logic [IDX_W-1:0]  owner;
  logic [IDX_W-1:0]  next_owner;
  logic [TMO_W-1:0]  tmo;
  logic [TMO_W-1:0]  next_tmo;
  logic              phase;
  logic              next_phase;
  logic              second;
  logic              next_second;
  logic              req;
  logic              next_req;
  logic              rx_en;
  logic              next_rx_en;
  logic [NUM_MODULES-1:0] drv_en;
  logic [NUM_MODULES-1:0] next_drv_en;
  logic              fail;
  logic              next_fail;
  logic [WORD_W-1:0] rdata;
  logic [WORD_W-1:0] next_rdata;

  logic              arb_any;
  logic [IDX_W-1:0]  arb_idx;
  logic              err_noacc;
  logic              err_par;
  logic              err_load;
  logic [WORD_W-1:0] err_info;
  logic [WORD_W-1:0] keep_mask;
  logic              spans;

  localparam logic [TMO_W-1:0] TMO_LIMIT = TMO_W'(NO_ACCESS_CYC);

  miu_arbiter #(
    .NUM_REQ   (NUM_REQ),
    .IDX_W     (IDX_W),
    .LOW_FIRST (LOW_FIRST)
  ) u_arb (
    .i_req (i_el_req),
    .o_any (arb_any),
    .o_idx (arb_idx)
  );

  // one-hot driver group from a module number
  function automatic logic [NUM_MODULES-1:0] grp_sel(input logic [MOD_IDX_W-1:0] m);
    grp_sel = NUM_MODULES'(1) << m;
  endfunction

  // a field that starts off a word boundary and runs past it needs a second module
  assign spans = (cw.ofs != 6'h0) &&
                 ({11'h000, cw.ofs} + {1'b0, cw.len} > 17'h0_0040); // one bit wider: no wrap
  // bits of the first word that survive the merge
  assign keep_mask = ~({WORD_W{1'b1}} >> cw.ofs);

  // timeout and parity faults, logged to the error register only while an interrupt is enabled
  assign err_noacc = (state == ST_MCW || state == ST_DATA || state == ST_FETCH) &&
                     (tmo == TMO_LIMIT);
  assign err_par   = (state == ST_FETCH) && i_mem.strobe &&
                     (miu_parity(i_mem.data) != i_mem.par);
  assign err_load  = (err_noacc || err_par) && i_intr_enable;
  assign err_info  = {err_noacc, err_par, cw[WORD_W-3:0]};

  miu_err_reg u_per (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_load  (err_load),
    .i_info  (err_info),
    .i_rd    (i_per_rd),
    .o_rdata (o_per_rdata),
    .o_full  (o_per_full)
  );

  // master control sequencing
  always_comb begin
    next_state   = state;
    next_cw      = cw;
    next_mbr     = mbr;
    next_mbr_par = mbr_par;
    next_dbr     = dbr;
    next_owner   = owner;
    next_tmo     = tmo;
    next_phase   = phase;
    next_second  = second;
    next_req     = req;
    next_rx_en   = rx_en;
    next_drv_en  = drv_en;
    next_fail    = fail;
    next_rdata   = rdata;
    if (state != ST_IDLE && state != ST_DONE) begin
      next_tmo = tmo + TMO_W'(1);
    end
    case (state)
      ST_IDLE: begin
        next_drv_en = '0;
        next_req    = 1'b0;
        next_rx_en  = 1'b0;
        if (arb_any) begin
          next_owner   = arb_idx;
          next_cw      = i_el_cw[arb_idx];
          next_dbr     = i_el_wdata[arb_idx];
          next_mbr     = i_el_cw[arb_idx];
          next_mbr_par = miu_parity(i_el_cw[arb_idx]);
          next_drv_en  = grp_sel(i_el_cw[arb_idx].module_sel);
          next_req     = 1'b1;
          next_tmo     = '0;
          next_phase   = 1'b0;
          next_second  = 1'b0;
          next_fail    = 1'b0;
          next_state   = ST_MCW;
        end
      end
      ST_MCW: begin
        if (cw.typ == TYPE_STORE) begin
          // single-word store alternates control word and data until acknowledged
          next_phase   = ~phase;
          next_mbr     = phase ? cw : dbr;
          next_mbr_par = phase ? miu_parity(cw) : miu_parity(dbr);
        end
        if (err_noacc) begin
          next_fail  = 1'b1;
          next_state = ST_DONE;
        end else if (i_mem.ack) begin
          next_tmo = '0;
          if (cw.typ == TYPE_STORE) begin
            next_state = ST_DONE;
          end else begin
            next_rx_en = 1'b1;
            next_state = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        if (err_noacc) begin
          next_fail  = 1'b1;
          next_state = ST_DONE;
        end else if (i_mem.strobe) begin
          next_mbr     = i_mem.data;
          next_mbr_par = i_mem.par;
          next_tmo     = '0;
          if (err_par) begin
            next_fail  = 1'b1;
            next_state = ST_DONE;
          end else if (second) begin
            next_dbr   = (dbr & keep_mask) | (i_mem.data & ~keep_mask);
            next_state = ST_DONE;
          end else if (spans) begin
            // hold the first word and go after the next module
            next_dbr           = i_mem.data;
            next_second        = 1'b1;
            next_cw.module_sel = cw.module_sel + MOD_IDX_W'(1);
            next_cw.addr_mid   = '1;
            next_cw.addr_hi    = '1;
            next_cw.link       = 1'b1;
            next_cw.len        = cw.len - (16'h0040 - {10'h000, cw.ofs});
            next_state         = ST_DATA;
            next_rx_en         = 1'b0;
            next_drv_en        = '0;
            next_req           = 1'b0;
          end else begin
            next_dbr   = i_mem.data;
            next_state = ST_DONE;
          end
        end
      end
      ST_DATA: begin
        // one idle cycle between modules so two groups never overlap
        next_mbr     = cw;
        next_mbr_par = miu_parity(cw);
        next_drv_en  = grp_sel(cw.module_sel);
        next_req     = 1'b1;
        next_tmo     = '0;
        next_state   = ST_MCW;
      end
      ST_DONE: begin
        next_rdata  = dbr;
        next_req    = 1'b0;
        next_rx_en  = 1'b0;
        next_drv_en = '0;
        next_state  = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state   <= ST_IDLE;
      cw      <= '0;
      mbr     <= 64'h0000_0000_0000_0000;
      mbr_par <= 1'b0;
      dbr     <= 64'h0000_0000_0000_0000;
      owner   <= '0;
      tmo     <= '0;
      phase   <= 1'b0;
      second  <= 1'b0;
      req     <= 1'b0;
      rx_en   <= 1'b0;
      drv_en  <= '0;
      fail    <= 1'b0;
      rdata   <= 64'h0000_0000_0000_0000;
    end else begin
      state   <= next_state;
      cw      <= next_cw;
      mbr     <= next_mbr;
      mbr_par <= next_mbr_par;
      dbr     <= next_dbr;
      owner   <= next_owner;
      tmo     <= next_tmo;
      phase   <= next_phase;
      second  <= next_second;
      req     <= next_req;
      rx_en   <= next_rx_en;
      drv_en  <= next_drv_en;
      fail    <= next_fail;
      rdata   <= next_rdata;
    end
  end

  // done and error pulses go to the owning element only
  logic [NUM_REQ-1:0] done_q;
  logic [NUM_REQ-1:0] next_done;
  logic [NUM_REQ-1:0] err_q;
  logic [NUM_REQ-1:0] next_err;
  logic               intr_q;
  logic               next_intr;

  always_comb begin
    next_done = '0;
    next_err  = '0;
    if (state == ST_DONE) begin
      next_done[owner] = 1'b1;
      next_err[owner]  = fail;
    end
    next_intr = err_load;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      done_q <= '0;
      err_q  <= '0;
      intr_q <= 1'b0;
    end else begin
      done_q <= next_done;
      err_q  <= next_err;
      intr_q <= next_intr;
    end
  end

  assign o_el_done   = done_q;
  assign o_el_err    = err_q;
  assign o_el_rdata  = rdata;
  assign o_busy      = (state != ST_IDLE);
  assign o_err_intr  = intr_q;
  assign o_mem.req    = req;
  assign o_mem.drv_en = drv_en;
  assign o_mem.rx_en  = rx_en;
  assign o_mem.data   = mbr;
  assign o_mem.par    = mbr_par;

endmodule
`default_nettype wire

// ---- hdl/miu_pkg.sv ----
package miu_pkg;

  localparam int WORD_W       = 64;
  localparam int NUM_MODULES  = 16;
  localparam int MOD_IDX_W    = 4;

  // element control word field positions
  localparam int CW_TYPE_POS  = 63;
  localparam int CW_JUST_POS  = 62;
  localparam int CW_LOCK_HI   = 61;
  localparam int CW_LOCK_LO   = 60;
  localparam int CW_LINK_POS  = 59;
  localparam int CW_LEN_HI    = 49;
  localparam int CW_LEN_LO    = 34;
  localparam int CW_ADDR_HI   = 33;
  localparam int CW_MOD_HI    = 17;
  localparam int CW_MOD_LO    = 14;
  localparam int CW_OFS_HI    = 5;
  localparam int CW_OFS_LO    = 0;

  localparam logic TYPE_FETCH = 1'b0;
  localparam logic TYPE_STORE = 1'b1;

  // even parity: the parity bit makes the count of ones even
  localparam logic PARITY_ODD_SENSE = 1'b0;

  // no-access timeout: longest time rounds down
  localparam int CLK_HZ          = 10_000_000;
  localparam int NO_ACCESS_NS    = 25_000;
  localparam int NO_ACCESS_CYC   = (NO_ACCESS_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int TMO_W           = 9;

  // error register layout
  localparam int ERR_KIND_NOACC  = 63;
  localparam int ERR_KIND_PAR    = 62;
  localparam logic [63:0] ERR_RESET = 64'h0000_0000_0000_0000;

  typedef struct packed {
    logic             typ;
    logic             just;
    logic [1:0]       lock;
    logic             link;
    logic [8:0]       spare;
    logic [15:0]      len;
    logic [15:0]      addr_hi;
    logic [3:0]       module_sel;
    logic [7:0]       addr_mid;
    logic [5:0]       ofs;
  } miu_cw_t;

  // signals toward the memory modules
  typedef struct packed {
    logic                   req;
    logic [NUM_MODULES-1:0] drv_en;
    logic                   rx_en;
    logic [WORD_W-1:0]      data;
    logic                   par;
  } miu_mem_out_t;

  // signals from the addressed memory module
  typedef struct packed {
    logic              ack;
    logic              data_req;
    logic              strobe;
    logic [WORD_W-1:0] data;
    logic              par;
  } miu_mem_in_t;

  function automatic logic miu_parity(input logic [WORD_W-1:0] w);
    miu_parity = (^w) ^ PARITY_ODD_SENSE;
  endfunction

endpackage

// ---- hdl/miu_arbiter.sv ----
`timescale 1ns/1ns
`default_nettype none
module miu_arbiter import miu_pkg::*; #(
  parameter int NUM_REQ   = 8,
  parameter int IDX_W     = 3,
  parameter bit LOW_FIRST = 1'b1
) (
  // requests
  input  wire logic [NUM_REQ-1:0] i_req,
  // grant
  output logic                    o_any,
  output logic [IDX_W-1:0]        o_idx
);

  // fixed order, direction chosen by parameter
  always_comb begin
    int j;
    j     = 0;
    o_any = 1'b0;
    o_idx = '0;
    for (int k = 0; k < NUM_REQ; k++) begin
      j = LOW_FIRST ? (NUM_REQ - 1 - k) : k;
      if (i_req[j]) begin
        o_any = 1'b1;
        o_idx = IDX_W'(j);
      end
    end
  end

endmodule
`default_nettype wire

// ---- hdl/miu_err_reg.sv ----
`timescale 1ns/1ns
`default_nettype none
module miu_err_reg import miu_pkg::*; (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // capture side
  input  wire logic              i_load,
  input  wire logic [WORD_W-1:0] i_info,
  // program read side
  input  wire logic              i_rd,
  output logic [WORD_W-1:0]      o_rdata,
  output logic                   o_full
);

  logic [WORD_W-1:0] processor_error_register;
  logic              full;
  logic [WORD_W-1:0] next_per;
  logic              next_full;
  logic [WORD_W-1:0] next_rdata;

  // read clears; a load in the read cycle still lands afterwards
  always_comb begin
    next_per   = processor_error_register;
    next_full  = full;
    next_rdata = o_rdata;
    if (i_rd) begin
      next_rdata = processor_error_register;
      next_per   = ERR_RESET;
      next_full  = 1'b0;
    end
    if (i_load && (!full || i_rd)) begin
      next_per  = i_info;
      next_full = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      processor_error_register     <= ERR_RESET;
      full    <= 1'b0;
      o_rdata <= ERR_RESET;
    end else begin
      processor_error_register     <= next_per;
      full    <= next_full;
      o_rdata <= next_rdata;
    end
  end

  assign o_full = full;

endmodule
`default_nettype wire

// ---- test/miu_top_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module miu_top_assertions import miu_pkg::*; #(
  parameter int NUM_REQ = 8
) (
  // clock and reset
  input wire logic               i_mclk,
  input wire logic               i_rst,
  // watched ports
  input wire logic [NUM_REQ-1:0] i_el_req,
  input wire logic [NUM_REQ-1:0] o_el_done,
  input wire logic [NUM_REQ-1:0] o_el_err,
  input wire miu_mem_out_t       o_mem,
  input wire logic               i_intr_enable,
  input wire logic               o_err_intr,
  input wire logic               i_per_rd,
  input wire logic               o_per_full
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // driver groups: never two at once, exactly one while a reference runs
  AST_ONE_GROUP: assert property ($onehot0(o_mem.drv_en))
    else $error("two driver groups enabled");
  AST_GROUP_REQ: assert property (o_mem.req |-> $onehot(o_mem.drv_en))
    else $error("reference without a driver group");
  AST_RX_IN_REF: assert property (o_mem.rx_en |-> o_mem.req)
    else $error("receivers on outside a reference");
  // only words on their way out carry generated parity; fetched ones keep theirs
  AST_EVEN_PAR: assert property (o_mem.req && !o_mem.rx_en |-> o_mem.par == ^o_mem.data)
    else $error("outgoing parity wrong");
  // completion only to an element that was asking
  AST_DONE_OWNER: assert property ((o_el_done & ~$past(i_el_req)) == '0)
    else $error("done to an idle element");
  AST_DONE_GAP: assert property (|o_el_done |=> (o_el_done == '0) [*3])
    else $error("operations overlap");
  AST_ERR_DONE: assert property ((o_el_err & ~o_el_done) == '0)
    else $error("error without done");
  // a silent module cannot hold the unit forever
  AST_REF_BOUND: assert property ($rose(o_mem.req) |-> ##[1:600] !o_mem.req)
    else $error("reference never ends");
  AST_INTR_GATE: assert property (o_err_intr |-> $past(i_intr_enable))
    else $error("interrupt while disabled");
  AST_LOAD_GATE: assert property ($rose(o_per_full) |-> $past(i_intr_enable))
    else $error("error register loaded without interrupt");
  AST_FULL_HOLD: assert property (o_per_full && !i_per_rd |=> o_per_full)
    else $error("error register lost");
  AST_READ_CLR: assert property (o_per_full && i_per_rd |=> !o_per_full || o_err_intr)
    else $error("read did not clear");

  CVR_FETCH: cover property (|o_el_done && o_el_err == '0);
  CVR_FAULT: cover property (|o_el_err);
  CVR_READ: cover property (o_per_full && i_per_rd);
  CVR_LINK: cover property (o_mem.req && !o_mem.rx_en && o_mem.data[CW_LINK_POS]);
endmodule

bind miu_top miu_top_assertions #(.NUM_REQ(NUM_REQ)) u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_el_req(i_el_req), .o_el_done(o_el_done),
  .o_el_err(o_el_err), .o_mem(o_mem), .i_intr_enable(i_intr_enable),
  .o_err_intr(o_err_intr), .i_per_rd(i_per_rd), .o_per_full(o_per_full)
);
`default_nettype wire

// ---- test/miu_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module miu_mem_model import miu_pkg::*; (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // unit side
  input  wire miu_mem_out_t      i_bus,
  output miu_mem_in_t            o_bus,
  // scenario controls
  input  wire logic [7:0]        i_delay,
  input  wire logic              i_mute,
  input  wire logic              i_bad_par,
  input  wire logic [WORD_W-1:0] i_word,
  output logic                   o_saw
);
  logic [7:0] cnt;
  logic [1:0] phase;

  // phase 0 waits to acknowledge, 1 waits to strobe, 2 has answered
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt   <= '0;
      phase <= '0;
      o_bus <= '0;
      o_saw <= 1'h0;
    end else begin
      o_bus.ack    <= 1'h0;
      o_bus.strobe <= 1'h0;
      // released lines toggle so a stale word never looks valid
      o_bus.data   <= ~o_bus.data;
      o_bus.par    <= ~o_bus.par;
      o_saw        <= i_bus.req && (o_saw || i_bus.data == i_word);
      if (!i_bus.req) begin
        cnt   <= '0;
        phase <= '0;
      end else if (cnt < i_delay || i_mute || phase == 2'h2) begin
        cnt <= cnt + 8'h01;
      end else if (phase == 2'h0) begin
        o_bus.ack <= 1'h1;
        phase     <= 2'h1;
        cnt       <= '0;
      end else if (i_bus.rx_en) begin
        o_bus.strobe <= 1'h1;
        o_bus.data   <= i_word;
        o_bus.par    <= (^i_word) ^ i_bad_par;
        phase        <= 2'h2;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/test_memory_interface_datapath.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_memory_interface_datapath import miu_pkg::*;;
  logic             i_mclk, i_rst, i_intr_enable, i_per_rd, mute, bad_par, saw;
  logic             o_busy, o_err_intr, o_per_full;
  logic [7:0]       req_q, i_el_req, o_el_done, o_el_err, done_v, err_v, dly;
  miu_cw_t [7:0]    cw_a;
  logic [7:0][63:0] wd_a;
  logic [63:0]      o_el_rdata, o_per_rdata, word, got;
  logic [15:0]      seen;
  miu_mem_out_t     o_mem;
  miu_mem_in_t      i_mem;
  int               failures, total_checks, intrs;

  // an element lets go of its request in the very cycle its done shows
  assign i_el_req = req_q & ~o_el_done;

  miu_top uut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_el_req(i_el_req), .i_el_cw(cw_a),
    .i_el_wdata(wd_a), .o_el_done(o_el_done), .o_el_err(o_el_err),
    .o_el_rdata(o_el_rdata), .o_busy(o_busy), .o_mem(o_mem), .i_mem(i_mem),
    .i_intr_enable(i_intr_enable), .o_err_intr(o_err_intr), .i_per_rd(i_per_rd),
    .o_per_rdata(o_per_rdata), .o_per_full(o_per_full)
  );
  miu_mem_model u_mem (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_bus(o_mem), .o_bus(i_mem), .i_delay(dly),
    .i_mute(mute), .i_bad_par(bad_par), .i_word(word), .o_saw(saw)
  );

  function automatic miu_cw_t mk(input logic t, input logic [3:0] m);
    mk            = '0;
    mk.typ        = t;
    mk.module_sel = m;
    mk.len        = 16'h0040;
  endfunction

  task automatic go(input logic [7:0] m, input miu_cw_t cw, input logic [63:0] wd);
    @(posedge i_mclk);
    for (int k = 0; k < 8; k++) begin
      if (m[k]) begin
        req_q[k] <= 1'h1;
        cw_a[k]  <= cw;
        wd_a[k]  <= wd;
      end
    end
  endtask

  // bounded wait for any completion, noting which groups were driven
  task automatic wait_done(output int n);
    n     = 0;
    seen  = '0;
    intrs = 0;
    do begin
      @(posedge i_mclk);
      n++;
      seen |= o_mem.drv_en;
      intrs += o_err_intr; // interrupt pulses during this operation
    end while (o_el_done === '0 && n < 1200);
    done_v = o_el_done;
    err_v  = o_el_err;
    got    = o_el_rdata;
    req_q <= req_q & ~o_el_done;
    `CHK(n < 1200, 1'h1)
  endtask

  task automatic rd_per;
    @(posedge i_mclk);
    i_per_rd <= 1'h1;
    @(posedge i_mclk);
    i_per_rd <= 1'h0;
    @(posedge i_mclk);
    got = o_per_rdata;
  endtask

  task automatic t_prio;
    int n;
    word = 64'h0123_4567_89ab_cdef;
    dly  = 8'h02;
    go(8'h24, mk(TYPE_FETCH, 4'h3), '0);
    wait_done(n);
    `CHK(done_v, 8'h04)
    `CHK(err_v, 8'h00)
    `CHK(got, word)
    `CHK(seen, 16'h0008)
    wait_done(n);
    `CHK(done_v, 8'h20)
    `CHK(got, word)
  endtask

  task automatic t_store;
    int n;
    word = 64'hfeed_0000_beef_1234;
    dly  = 8'h03;
    go(8'h40, mk(TYPE_STORE, 4'hf), word);
    wait_done(n);
    `CHK(done_v, 8'h40)
    `CHK(err_v, 8'h00)
    `CHK(saw, 1'h1)
    `CHK(seen, 16'h8000)
  endtask

  task automatic t_faults;
    int      n;
    miu_cw_t c1;
    c1          = mk(TYPE_FETCH, 4'h7);
    c1.addr_mid = 8'h5a;
    bad_par     = 1'h1;
    i_intr_enable <= 1'h1;
    go(8'h02, c1, '0);
    wait_done(n);
    `CHK(err_v, 8'h02)
    `CHK(o_per_full, 1'h1)
    `CHK(intrs, 1)
    bad_par = 1'h0;
    mute    = 1'h1;
    go(8'h08, mk(TYPE_FETCH, 4'h9), '0);
    wait_done(n);
    `CHK(err_v, 8'h08)
    `CHK(n inside {[250:260]}, 1'h1)
    rd_per;
    `CHK(got[62], 1'h1)
    `CHK(got[61:0], c1[61:0])
    `CHK(o_per_full, 1'h0)
    i_intr_enable <= 1'h0;
    go(8'h01, mk(TYPE_STORE, 4'h0), '0);
    wait_done(n);
    `CHK(err_v, 8'h01)
    `CHK(o_per_full, 1'h0)
    `CHK(intrs, 0)
    i_intr_enable <= 1'h1;
    go(8'h80, c1, '0);
    wait_done(n);
    rd_per;
    `CHK(got[63], 1'h1)
    `CHK(got[61:0], c1[61:0])
    mute = 1'h0;
  endtask

  // a field that starts mid-word and runs past it takes a second module
  task automatic t_link;
    int      n;
    miu_cw_t c2;
    c2     = mk(TYPE_FETCH, 4'h2);
    c2.ofs = 6'h10;
    word   = 64'haaaa_bbbb_cccc_dddd;
    dly    = 8'h02;
    go(8'h10, c2, '0);
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_mem.drv_en !== 16'h0008 && n < 100);
    `CHK(o_mem.drv_en, 16'h0008)
    `CHK(o_busy, 1'h1)
    `CHK(o_mem.data[CW_LINK_POS], 1'h1)
    `CHK(o_mem.data[CW_MOD_HI:CW_MOD_LO], 4'h3)
    `CHK(o_mem.data[CW_ADDR_HI:CW_MOD_HI+1], 16'hffff)
    // the second module answers with a different word so the merge shows
    word <= 64'h1111_2222_3333_4444;
    wait_done(n);
    `CHK(err_v, 8'h00)
    `CHK(seen, 16'h0008)
    `CHK(got, 64'haaaa_2222_3333_4444)
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // clock at 100 ns
  initial begin
    i_mclk = 1'h0;
    forever #50 i_mclk = ~i_mclk;
  end

  // run is under 1,000 cycles; give it fifteen times that
  initial begin
    #1_500_000;
    failures++;
    complete_run;
  end

  initial begin
    i_rst = 1'h1;
    {i_intr_enable, i_per_rd, mute, bad_par} = '0;
    req_q = '0;
    cw_a  = '0;
    wd_a  = '0;
    word  = '0;
    dly   = '0;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'h0;
    t_prio;
    t_store;
    t_link;
    t_faults;
    complete_run;
  end
endmodule
`default_nettype wire
